// File: rtl/addon_port_regs.svh
`ifndef ADDON_PORT_REGS_SVH
`define ADDON_PORT_REGS_SVH
`define ADDR_FIFO_PORT      7'h20
`define ADDR_PASSTHRU_ADDR  7'h28
`define ADDR_PASSTHRU_DATA  7'h2C
`define ADDR_MAILBOX_OUT4   7'h1C
`define ADDR_MAILBOX_IN4    7'h0C
`define MBOX_BYTE3_LSB      24
`define FIFO_DEPTH_DEF      8
`define BOOT_PIN_WIDTH      9
`endif

// File: rtl/addon_port_pkg.sv
package addon_port_pkg;
    typedef logic [31:0] word_t;
    typedef logic [6:0]  addr_t;
    typedef enum logic [1:0]
    {
        PT_IDLE  = 2'b00,
        PT_READ  = 2'b01,
        PT_WRITE = 2'b10
    } pt_state_t;
endpackage

// File: rtl/addon_port_if.sv
`timescale 1ns/1ps
interface addon_port_if;
    import addon_port_pkg::*;
    logic        select_n;
    logic        rd_n;
    logic        wr_n;
    logic        fifo_direct_read_n;
    logic        fifo_direct_write_n;
    logic        passthru_address_direct_n;
    logic        passthru_ready_n;
    logic        outbound_fifo_clear_n;
    logic        inbound_fifo_clear_n;
    logic        master_read_enable;
    logic        master_write_enable;
    logic        width_mode;
    logic [6:2]  adr;
    logic [3:0]  byte_lane_enables_n;
    word_t       dq_to_dev;
    word_t       dq_from_dev;
    logic        dq_oe;
    logic        out_fifo_full;
    logic        in_fifo_empty;
    logic        irq_n;
    modport device
    (
        input  select_n, rd_n, wr_n, fifo_direct_read_n, fifo_direct_write_n,
        input  passthru_address_direct_n, passthru_ready_n, outbound_fifo_clear_n,
        input  inbound_fifo_clear_n, master_read_enable, master_write_enable,
        input  width_mode, adr, byte_lane_enables_n, dq_to_dev,
        output dq_from_dev, dq_oe, out_fifo_full, in_fifo_empty, irq_n
    );
    modport addon
    (
        output select_n, rd_n, wr_n, fifo_direct_read_n, fifo_direct_write_n,
        output passthru_address_direct_n, passthru_ready_n, outbound_fifo_clear_n,
        output inbound_fifo_clear_n, master_read_enable, master_write_enable,
        output width_mode, adr, byte_lane_enables_n, dq_to_dev,
        input  dq_from_dev, dq_oe, out_fifo_full, in_fifo_empty, irq_n
    );
endinterface // addon_port_if

// File: rtl/word_fifo.sv
`timescale 1ns/1ps
`include "addon_port_regs.svh"
module word_fifo #(
    parameter int DEPTH = `FIFO_DEPTH_DEF
)(
    input  wire logic                 CLK,
    input  wire logic                 RST_N,
    input  wire logic                 clear,
    input  wire logic                 push,
    input  wire addon_port_pkg::word_t push_data,
    input  wire logic                 pop,
    output addon_port_pkg::word_t     head,
    output logic                      full,
    output logic                      empty
);
    import addon_port_pkg::*;
    localparam int AW = $clog2(DEPTH);
    typedef struct packed
    {
        logic [DEPTH-1:0][31:0] mem;
        logic [AW-1:0]          wp;
        logic [AW-1:0]          rp;
        logic [AW:0]            cnt;
    } fifo_state_t;
    fifo_state_t st_reg;
    fifo_state_t st_next;
    logic do_push;
    logic do_pop;
    always_comb
    begin
        st_next = st_reg;
        do_push = push && (int'(st_reg.cnt) < DEPTH);
        do_pop  = pop && (st_reg.cnt != '0);
        if (do_push)
        begin
            st_next.mem[st_reg.wp] = push_data;
            st_next.wp = (int'(st_reg.wp) == DEPTH - 1) ? '0 : st_reg.wp + 1'b1;
        end
        if (do_pop)
        begin
            st_next.rp = (int'(st_reg.rp) == DEPTH - 1) ? '0 : st_reg.rp + 1'b1;
        end
        st_next.cnt = st_reg.cnt + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
        if (clear)
        begin
            st_next.wp  = '0;
            st_next.rp  = '0;
            st_next.cnt = '0;
        end
    end
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end
    assign head  = st_reg.mem[st_reg.rp];
    assign full  = (int'(st_reg.cnt) == DEPTH);
    assign empty = (st_reg.cnt == '0);
endmodule // word_fifo

// File: rtl/addon_device_end.sv
`timescale 1ns/1ps
`include "addon_port_regs.svh"
module addon_device_end #(
    parameter int FIFO_DEPTH = `FIFO_DEPTH_DEF
)(
    input  wire logic                  CLK,
    input  wire logic                  RST_N,
    addon_port_if.device               port,
    input  wire logic                  BUS_FIFO_PUSH,
    input  wire addon_port_pkg::word_t BUS_FIFO_DATA,
    input  wire logic                  BUS_FIFO_POP,
    output addon_port_pkg::word_t      BUS_FIFO_HEAD,
    input  wire logic                  BUS_PT_VALID,
    input  wire logic                  BUS_PT_IS_READ,
    input  wire addon_port_pkg::word_t BUS_PT_ADDR,
    input  wire addon_port_pkg::word_t BUS_PT_RDATA,
    output logic                       BUS_PT_DONE,
    output addon_port_pkg::word_t      BUS_PT_WDATA,
    input  wire logic                  SERIAL_BOOT,
    input  wire logic [8:0]            BOOT_ADDRESS_PINS,
    input  wire logic                  BUS_MBOX_WR,
    input  wire addon_port_pkg::word_t BUS_MBOX_WDATA,
    input  wire logic                  BUS_MBOX_RD,
    input  wire logic [3:0]            IRQ_BYTE_SEL_OUT,
    input  wire logic [3:0]            IRQ_BYTE_SEL_IN,
    input  wire logic                  IRQ_ENABLE,
    output logic                       BUS_REQ_N,
    output logic                       BUS_INT_N
);
    import addon_port_pkg::*;
    typedef struct packed
    {
        word_t      dq;
        logic       oe;
        logic       ofull;
        logic       iempty;
        logic       irq_n;
        logic       req_n;
        logic       int_n;
        logic       half_hi;
        logic [15:0] low_half;
        word_t      mbox_out;
        logic [3:0] mbox_out_full;
        word_t      mbox_in;
        logic [3:0] mbox_in_full;
        pt_state_t  pt;
        word_t      pt_data;
        logic       pt_done;
    } dev_state_t;
    dev_state_t s_reg;
    dev_state_t s_next;
    logic   fifo_rd;
    logic   fifo_wr;
    logic   norm_rd;
    logic   norm_wr;
    addr_t  eff_adr;
    logic   out_push;
    logic   in_pop;
    word_t  out_word;
    word_t  in_head;
    logic   out_full;
    logic   out_empty;
    logic   in_full;
    logic   in_empty;
    logic [15:0] rd_half;
    word_t  rd_word;
    always_comb
    begin
        fifo_rd = !port.fifo_direct_read_n;
        fifo_wr = !port.fifo_direct_write_n;
        norm_rd = !port.select_n && !port.rd_n;
        norm_wr = !port.select_n && !port.wr_n;
        eff_adr = {port.adr, 2'b00};
        if (fifo_rd || fifo_wr)
            eff_adr = `ADDR_FIFO_PORT;
        else if (!port.passthru_address_direct_n)
            eff_adr = `ADDR_PASSTHRU_ADDR;
        fifo_rd = fifo_rd || (norm_rd && eff_adr == `ADDR_FIFO_PORT);
        fifo_wr = fifo_wr || (norm_wr && eff_adr == `ADDR_FIFO_PORT);
        out_word = {port.dq_to_dev[15:0], s_reg.low_half};
        if (!port.width_mode)
            out_word = port.dq_to_dev;
        out_push = fifo_wr && (!port.width_mode || s_reg.half_hi);
        in_pop   = fifo_rd && (!port.width_mode || s_reg.half_hi);
    end
    word_fifo #(.DEPTH(FIFO_DEPTH)) u_out_fifo
    (
        .CLK       (CLK),
        .RST_N     (RST_N),
        .clear     (!port.outbound_fifo_clear_n),
        .push      (out_push),
        .push_data (out_word),
        .pop       (BUS_FIFO_POP),
        .head      (BUS_FIFO_HEAD),
        .full      (out_full),
        .empty     (out_empty)
    );
    word_fifo #(.DEPTH(FIFO_DEPTH)) u_in_fifo
    (
        .CLK       (CLK),
        .RST_N     (RST_N),
        .clear     (!port.inbound_fifo_clear_n),
        .push      (BUS_FIFO_PUSH),
        .push_data (BUS_FIFO_DATA),
        .pop       (in_pop),
        .head      (in_head),
        .full      (in_full),
        .empty     (in_empty)
    );
    always_comb
    begin
        s_next = s_reg;
        s_next.pt_done = 1'b0;
        rd_word = '0;
        case (eff_adr)
            `ADDR_FIFO_PORT:     rd_word = in_head;
            `ADDR_PASSTHRU_ADDR: rd_word = BUS_PT_ADDR;
            `ADDR_PASSTHRU_DATA: rd_word = s_reg.pt_data;
            `ADDR_MAILBOX_IN4:   rd_word = s_reg.mbox_in;
            `ADDR_MAILBOX_OUT4:  rd_word = s_reg.mbox_out;
            default:             rd_word = '0;
        endcase
        rd_half = port.byte_lane_enables_n[3] ? rd_word[31:16] : rd_word[15:0];
        if (fifo_rd && port.width_mode)
            rd_half = s_reg.half_hi ? rd_word[31:16] : rd_word[15:0];
        if (!port.passthru_address_direct_n && port.width_mode)
            rd_half = rd_word[15:0];
        if (port.width_mode)
            rd_word = {16'h0000, rd_half};
        s_next.oe = norm_rd || !port.fifo_direct_read_n
                    || !port.passthru_address_direct_n;
        s_next.dq = rd_word;
        if (fifo_rd || fifo_wr)
            s_next.half_hi = port.width_mode ? !s_reg.half_hi : 1'b0;
        if (fifo_wr && port.width_mode && !s_reg.half_hi)
            s_next.low_half = port.dq_to_dev[15:0];
        s_next.ofull  = out_full;
        s_next.iempty = in_empty;
        if (BUS_MBOX_RD)
            s_next.mbox_out_full = 4'h0;
        if (norm_wr && eff_adr == `ADDR_MAILBOX_OUT4)
        begin
            s_next.mbox_out = port.dq_to_dev;
            s_next.mbox_out_full = ~port.byte_lane_enables_n | s_next.mbox_out_full;
        end
        if (SERIAL_BOOT)
        begin
            s_next.mbox_out[`MBOX_BYTE3_LSB +: 8] = BOOT_ADDRESS_PINS[7:0];
            s_next.mbox_out_full[3] = s_next.mbox_out_full[3] | BOOT_ADDRESS_PINS[8];
        end
        if (BUS_MBOX_WR)
        begin
            s_next.mbox_in = BUS_MBOX_WDATA;
            s_next.mbox_in_full = 4'hF;
        end
        if (norm_rd && eff_adr == `ADDR_MAILBOX_IN4 && !BUS_MBOX_WR)
            s_next.mbox_in_full = 4'h0;
        s_next.irq_n = !(IRQ_ENABLE && (|(IRQ_BYTE_SEL_IN & s_reg.mbox_in_full)
                       || |(IRQ_BYTE_SEL_OUT & ~s_reg.mbox_out_full)));
        s_next.int_n = !(IRQ_ENABLE && |(IRQ_BYTE_SEL_OUT & s_reg.mbox_out_full));
        s_next.req_n = !((port.master_write_enable && !out_empty)
                       || (port.master_read_enable && !in_full));
        case (s_reg.pt)
            PT_IDLE:
            begin
                if (BUS_PT_VALID)
                begin
                    s_next.pt = BUS_PT_IS_READ ? PT_READ : PT_WRITE;
                    if (BUS_PT_IS_READ)
                        s_next.pt_data = BUS_PT_RDATA;
                end
            end
            PT_READ, PT_WRITE:
            begin
                if (norm_wr && eff_adr == `ADDR_PASSTHRU_DATA)
                    s_next.pt_data = port.dq_to_dev;
                if (!port.passthru_ready_n)
                begin
                    s_next.pt_done = 1'b1;
                    s_next.pt = PT_IDLE;
                end
            end
            default: s_next.pt = PT_IDLE;
        endcase
    end
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            s_reg <= '0;
            s_reg.irq_n <= 1'b1;
            s_reg.req_n <= 1'b1;
            s_reg.int_n <= 1'b1;
            s_reg.iempty <= 1'b1;
        end
        else
            s_reg <= s_next;
    end
    assign port.dq_from_dev  = s_reg.dq;
    assign port.dq_oe        = s_reg.oe;
    assign port.out_fifo_full = s_reg.ofull;
    assign port.in_fifo_empty = s_reg.iempty;
    assign port.irq_n        = s_reg.irq_n;
    assign BUS_REQ_N   = s_reg.req_n;
    assign BUS_INT_N   = s_reg.int_n;
    assign BUS_PT_DONE = s_reg.pt_done;
    assign BUS_PT_WDATA = s_reg.pt_data;
endmodule // addon_device_end

// File: rtl/addon_logic_end.sv
`timescale 1ns/1ps
`include "addon_port_regs.svh"
module addon_logic_end
(
    input  wire logic                  CLK,
    input  wire logic                  RST_N,
    addon_port_if.addon                port,
    input  wire logic                  REQ_VALID,
    input  wire logic                  REQ_WRITE,
    input  wire logic                  REQ_DIRECT,
    input  wire logic [6:2]            REQ_ADR,
    input  wire addon_port_pkg::word_t REQ_WDATA,
    input  wire logic                  REQ_PT_READY,
    input  wire logic                  CLEAR_OUT,
    input  wire logic                  CLEAR_IN,
    input  wire logic                  MASTER_RD,
    input  wire logic                  MASTER_WR,
    input  wire logic                  WIDTH16,
    output addon_port_pkg::word_t      RSP_DATA,
    output logic                       RSP_VALID
);
    import addon_port_pkg::*;
    typedef struct packed
    {
        logic  select_n;
        logic  rd_n;
        logic  wr_n;
        logic  frd_n;
        logic  fwr_n;
        logic  ptr_n;
        logic  pta_n;
        logic  ofc_n;
        logic  ifc_n;
        logic  mre;
        logic  mwe;
        logic  mode;
        logic [6:2] adr;
        word_t wdata;
        logic  rd_pend;
        logic  rd_pend2;
        word_t rsp;
        logic  rsp_v;
    } host_state_t;
    host_state_t h_reg;
    host_state_t h_next;
    always_comb
    begin
        h_next = h_reg;
        h_next.select_n = 1'b1;
        h_next.rd_n  = 1'b1;
        h_next.wr_n  = 1'b1;
        h_next.frd_n = 1'b1;
        h_next.fwr_n = 1'b1;
        h_next.pta_n = 1'b1;
        h_next.ofc_n = !CLEAR_OUT;
        h_next.ifc_n = !CLEAR_IN;
        h_next.mre   = MASTER_RD;
        h_next.mwe   = MASTER_WR;
        h_next.mode  = WIDTH16;
        h_next.ptr_n = !REQ_PT_READY;
        h_next.rsp_v = 1'b0;
        if (REQ_VALID)
        begin
            h_next.adr   = REQ_ADR;
            h_next.wdata = REQ_WDATA;
            if (REQ_DIRECT && !REQ_WRITE && {REQ_ADR, 2'b00} == `ADDR_PASSTHRU_ADDR)
                h_next.pta_n = 1'b0;
            else if (REQ_DIRECT)
            begin
                h_next.frd_n = REQ_WRITE;
                h_next.fwr_n = !REQ_WRITE;
            end
            else
            begin
                h_next.select_n = 1'b0;
                h_next.rd_n = REQ_WRITE;
                h_next.wr_n = !REQ_WRITE;
            end
        end
        h_next.rd_pend  = REQ_VALID && !REQ_WRITE;
        h_next.rd_pend2 = h_reg.rd_pend;
        if (h_reg.rd_pend2)
        begin
            h_next.rsp   = port.dq_from_dev;
            h_next.rsp_v = 1'b1;
        end
    end
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            h_reg <= '0;
            h_reg.select_n <= 1'b1;
            h_reg.rd_n  <= 1'b1;
            h_reg.wr_n  <= 1'b1;
            h_reg.frd_n <= 1'b1;
            h_reg.fwr_n <= 1'b1;
            h_reg.ptr_n <= 1'b1;
            h_reg.pta_n <= 1'b1;
            h_reg.ofc_n <= 1'b1;
            h_reg.ifc_n <= 1'b1;
        end
        else
            h_reg <= h_next;
    end
    assign port.select_n = h_reg.select_n;
    assign port.rd_n = h_reg.rd_n;
    assign port.wr_n = h_reg.wr_n;
    assign port.fifo_direct_read_n = h_reg.frd_n;
    assign port.fifo_direct_write_n = h_reg.fwr_n;
    assign port.passthru_address_direct_n = h_reg.pta_n;
    assign port.passthru_ready_n = h_reg.ptr_n;
    assign port.outbound_fifo_clear_n = h_reg.ofc_n;
    assign port.inbound_fifo_clear_n = h_reg.ifc_n;
    assign port.master_read_enable = h_reg.mre;
    assign port.master_write_enable = h_reg.mwe;
    assign port.width_mode = h_reg.mode;
    assign port.adr = h_reg.adr;
    assign port.byte_lane_enables_n = 4'h0;
    assign port.dq_to_dev = h_reg.wdata;
    assign RSP_DATA  = h_reg.rsp;
    assign RSP_VALID = h_reg.rsp_v;
endmodule // addon_logic_end

// File: verif/addon_port_sva.sv
`timescale 1ns/1ps
module addon_port_sva
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic select_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic fifo_direct_read_n,
    input wire logic fifo_direct_write_n,
    input wire logic passthru_address_direct_n,
    input wire logic outbound_fifo_clear_n,
    input wire logic inbound_fifo_clear_n,
    input wire logic dq_oe,
    input wire logic out_fifo_full,
    input wire logic in_fifo_empty
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    AST_OE_RD: assert property (!rd_n && !select_n |=> dq_oe)
        else $error("Data bus not driven after read strobe");
    AST_OE_DIRECT: assert property (!fifo_direct_read_n |=> dq_oe)
        else $error("Data bus not driven after direct read");
    AST_OE_OFF: assert property (rd_n && fifo_direct_read_n
        && passthru_address_direct_n |=> !dq_oe)
        else $error("Data bus driven without read strobe");
    AST_STROBE_EXCL: assert property (!(fifo_direct_read_n && fifo_direct_write_n
        && passthru_address_direct_n) |-> rd_n && wr_n)
        else $error("Normal strobe low during direct access");
    AST_CLR_IN: assert property (!inbound_fifo_clear_n |-> ##2 in_fifo_empty)
        else $error("Inbound clear did not empty the fifo");
    AST_CLR_OUT: assert property (!outbound_fifo_clear_n |-> ##2 !out_fifo_full)
        else $error("Outbound clear left the fifo full");
    AST_FULL_CAUSE: assert property ($rose(out_fifo_full) |->
        $past(!wr_n || !fifo_direct_write_n, 2))
        else $error("Full flag rose without a write two edges before");
    AST_EMPTY_CAUSE: assert property ($rose(in_fifo_empty) |->
        $past(!rd_n || !fifo_direct_read_n || !inbound_fifo_clear_n, 2))
        else $error("Empty flag rose without a read or clear");
    cover property (!fifo_direct_read_n ##1 !fifo_direct_read_n);
    cover property (!wr_n ##1 !fifo_direct_write_n);
    cover property ($rose(out_fifo_full));
endmodule // addon_port_sva

// File: verif/addon_fifo_passthru_port_test.sv
`timescale 1ns/1ps
module addon_fifo_passthru_port_test;
    import addon_port_pkg::*;
    localparam int DEPTH = 4;
    logic       CLK, RST_N, req_valid, req_write, req_direct, pt_ready, clr_out, clr_in;
    logic       master_rd, master_wr, width16, rsp_valid, bus_fifo_push, bus_fifo_pop;
    logic       bus_pt_valid, bus_pt_is_read, bus_pt_done, serial_boot, bus_mbox_wr;
    logic       bus_mbox_rd, irq_enable, bus_req_n, bus_int_n;
    logic [6:2] req_adr;
    logic [8:0] boot_pins;
    logic [3:0] irq_sel_out, irq_sel_in;
    word_t      req_wdata, rsp_data, bus_fifo_data, bus_fifo_head, bus_pt_addr;
    word_t      bus_pt_rdata, bus_pt_wdata, bus_mbox_wdata;
    word_t      expq [$];
    int         miscompares = 0;
    int         samples_checked = 0;
    addon_port_if aif ();
    addon_device_end #(.FIFO_DEPTH(DEPTH)) addon_device_end_inst (.CLK(CLK), .RST_N(RST_N),
        .port(aif.device), .BUS_FIFO_PUSH(bus_fifo_push), .BUS_FIFO_DATA(bus_fifo_data),
        .BUS_FIFO_POP(bus_fifo_pop), .BUS_FIFO_HEAD(bus_fifo_head), .BUS_PT_VALID(bus_pt_valid),
        .BUS_PT_IS_READ(bus_pt_is_read), .BUS_PT_ADDR(bus_pt_addr), .BUS_PT_RDATA(bus_pt_rdata),
        .BUS_PT_DONE(bus_pt_done), .BUS_PT_WDATA(bus_pt_wdata), .SERIAL_BOOT(serial_boot),
        .BOOT_ADDRESS_PINS(boot_pins), .BUS_MBOX_WR(bus_mbox_wr), .BUS_MBOX_WDATA(bus_mbox_wdata),
        .BUS_MBOX_RD(bus_mbox_rd), .IRQ_BYTE_SEL_OUT(irq_sel_out), .IRQ_BYTE_SEL_IN(irq_sel_in),
        .IRQ_ENABLE(irq_enable), .BUS_REQ_N(bus_req_n), .BUS_INT_N(bus_int_n));
    addon_logic_end addon_logic_end_inst (.CLK(CLK), .RST_N(RST_N), .port(aif.addon),
        .REQ_VALID(req_valid), .REQ_WRITE(req_write), .REQ_DIRECT(req_direct), .REQ_ADR(req_adr),
        .REQ_WDATA(req_wdata), .REQ_PT_READY(pt_ready), .CLEAR_OUT(clr_out), .CLEAR_IN(clr_in),
        .MASTER_RD(master_rd), .MASTER_WR(master_wr), .WIDTH16(width16),
        .RSP_DATA(rsp_data), .RSP_VALID(rsp_valid));
    addon_port_sva addon_port_sva_inst (.CLK(CLK), .RST_N(RST_N), .select_n(aif.select_n),
        .rd_n(aif.rd_n), .wr_n(aif.wr_n), .fifo_direct_read_n(aif.fifo_direct_read_n),
        .fifo_direct_write_n(aif.fifo_direct_write_n),
        .passthru_address_direct_n(aif.passthru_address_direct_n),
        .outbound_fifo_clear_n(aif.outbound_fifo_clear_n),
        .inbound_fifo_clear_n(aif.inbound_fifo_clear_n), .dq_oe(aif.dq_oe),
        .out_fifo_full(aif.out_fifo_full), .in_fifo_empty(aif.in_fifo_empty));
    always #10 CLK = ~CLK;
    task automatic check(input word_t seen, input word_t exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("Mismatches %0d, comparisons %0d", miscompares, samples_checked);
        if (miscompares == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic req(input logic wr, input logic dir, input logic [6:2] adr, input word_t d);
        @(posedge CLK);
        req_valid <= 1'b1;
        req_write <= wr;
        req_direct <= dir;
        req_adr <= adr;
        req_wdata <= d;
    endtask
    task automatic idle(input int n);
        @(posedge CLK);
        req_valid <= 1'b0;
        repeat (n) @(posedge CLK);
    endtask
    task automatic drain();
        for (int i = 0; i < 40 && expq.size() > 0; i++)
            @(posedge CLK);
        if (expq.size() > 0)
        begin
            miscompares++;
            close_out();
        end
    endtask
    task automatic bus_push(input word_t d);
        @(posedge CLK);
        bus_fifo_push <= 1'b1;
        bus_fifo_data <= d;
        @(posedge CLK);
        bus_fifo_push <= 1'b0;
    endtask
    task automatic pt_start(input logic rd, input word_t a, input word_t d);
        @(posedge CLK);
        bus_pt_valid <= 1'b1;
        bus_pt_is_read <= rd;
        bus_pt_addr <= a;
        bus_pt_rdata <= d;
        @(posedge CLK);
        bus_pt_valid <= 1'b0;
    endtask
    task automatic pt_finish();
        int n;
        n = 0;
        @(posedge CLK);
        pt_ready <= 1'b1;
        while (bus_pt_done !== 1'b1 && n < 20)
        begin
            @(posedge CLK);
            #1;
            n++;
        end
        if (n == 20)
        begin
            miscompares++;
            close_out();
        end
        @(posedge CLK);
        pt_ready <= 1'b0;
    endtask
    always @(posedge CLK)
    begin
        if (RST_N === 1'b1 && rsp_valid === 1'b1)
        begin
            if (expq.size() == 0)
            begin
                miscompares++;
                $display("Error at %0t: unexpected response", $time);
            end
            else
                check(rsp_data, expq.pop_front());
        end
    end
    initial
    begin
        repeat (20000) @(posedge CLK);
        miscompares++;
        close_out();
    end
    initial
    begin
        word_t w [4];
        word_t a;
        word_t d;
        CLK = 1'b0;
        RST_N = 1'b0;
        {req_valid, req_write, req_direct, pt_ready, clr_out, clr_in, master_rd} = '0;
        {master_wr, width16, bus_fifo_push, bus_fifo_pop, bus_pt_valid, bus_pt_is_read} = '0;
        {serial_boot, bus_mbox_wr, bus_mbox_rd, irq_enable, irq_sel_out, irq_sel_in} = '0;
        {req_adr, boot_pins, req_wdata, bus_fifo_data, bus_pt_addr, bus_pt_rdata} = '0;
        bus_mbox_wdata = '0;
        void'($urandom(32'h3fdb2492));
        repeat (3) @(posedge CLK);
        RST_N <= 1'b1;
        @(posedge CLK);
        #1 check({26'h0, aif.dq_oe, aif.out_fifo_full, aif.in_fifo_empty, aif.irq_n,
            bus_req_n, bus_int_n}, 32'hF);
        // Inbound burst, normal and direct reads back to back
        for (int i = 0; i < 4; i++)
        begin
            w[i] = $urandom();
            bus_push(w[i]);
        end
        repeat (2) @(posedge CLK);
        for (int i = 0; i < 4; i++)
        begin
            expq.push_back(w[i]);
            req(1'b0, i[0], i[0] ? 5'($urandom() | 32'h10) : 5'h08, 32'h0);
        end
        idle(2);
        drain();
        #1 check({31'h0, aif.in_fifo_empty}, 32'h1);
        @(posedge CLK);
        master_rd <= 1'b1;
        repeat (4) @(posedge CLK);
        #1 check({31'h0, bus_req_n}, 32'h0);
        @(posedge CLK);
        master_rd <= 1'b0;
        // Outbound burst until full, one refused write
        for (int i = 0; i < 4; i++)
        begin
            w[i] = $urandom();
            req(1'b1, i[0], i[0] ? 5'($urandom()) : 5'h08, w[i]);
        end
        req(1'b1, 1'b1, 5'h00, 32'hDEAD_BEEF);
        idle(3);
        #1 check({31'h0, aif.out_fifo_full}, 32'h1);
        @(posedge CLK);
        master_wr <= 1'b1;
        repeat (4) @(posedge CLK);
        #1 check({31'h0, bus_req_n}, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge CLK);
            bus_fifo_pop <= 1'b0;
            master_wr <= 1'b0;
            #1 check(bus_fifo_head, w[i]);
            @(posedge CLK);
            bus_fifo_pop <= 1'b1;
        end
        @(posedge CLK);
        bus_fifo_pop <= 1'b0;
        // Clears: inbound with data, outbound then refill with three words, one short of depth
        bus_push($urandom());
        bus_push($urandom());
        @(posedge CLK);
        clr_in <= 1'b1;
        @(posedge CLK);
        clr_in <= 1'b0;
        repeat (3) @(posedge CLK);
        #1 check({31'h0, aif.in_fifo_empty}, 32'h1);
        req(1'b1, 1'b1, 5'h00, $urandom());
        req(1'b1, 1'b0, 5'h08, $urandom());
        idle(2);
        clr_out <= 1'b1;
        @(posedge CLK);
        clr_out <= 1'b0;
        repeat (2) @(posedge CLK);
        for (int i = 0; i < 3; i++)
        begin
            w[i] = $urandom();
            req(1'b1, 1'b1, 5'h00, w[i]);
        end
        idle(3);
        #1 check({31'h0, aif.out_fifo_full}, 32'h0);
        check(bus_fifo_head, w[0]);
        // Mailbox written from the bus side, read by the add-on side
        d = $urandom();
        @(posedge CLK);
        irq_enable <= 1'b1;
        irq_sel_in <= 4'h1;
        bus_mbox_wr <= 1'b1;
        bus_mbox_wdata <= d;
        @(posedge CLK);
        bus_mbox_wr <= 1'b0;
        repeat (3) @(posedge CLK);
        #1 check({31'h0, aif.irq_n}, 32'h0);
        expq.push_back(d);
        req(1'b0, 1'b0, 5'h03, 32'h0);
        idle(2);
        drain();
        // Pass-thru read: address view, data held until ready
        a = $urandom();
        d = $urandom();
        pt_start(1'b1, a, d);
        expq.push_back(a);
        req(1'b0, 1'b0, 5'h0A, 32'h0);
        expq.push_back(a);
        req(1'b0, 1'b1, 5'h0A, 32'h0);
        expq.push_back(d);
        req(1'b0, 1'b0, 5'h0B, 32'h0);
        expq.push_back(d);
        req(1'b0, 1'b0, 5'h0B, 32'h0);
        idle(4);
        drain();
        pt_finish();
        // Pass-thru write: last captured word forwarded on ready
        pt_start(1'b0, a, 32'h0);
        req(1'b1, 1'b0, 5'h0B, d);
        w[0] = $urandom();
        req(1'b1, 1'b0, 5'h0B, w[0]);
        idle(4);
        pt_finish();
        check(bus_pt_wdata, w[0]);
        // Bus push status lag, 16-bit halves, boot pins into mailbox
        d = $urandom();
        bus_push(d);
        #1 check({31'h0, aif.in_fifo_empty}, 32'h1);
        @(posedge CLK);
        width16 <= 1'b1;
        #1 check({31'h0, aif.in_fifo_empty}, 32'h0);
        expq.push_back({16'h0, d[15:0]});
        req(1'b0, 1'b1, 5'h00, 32'h0);
        expq.push_back({16'h0, d[31:16]});
        req(1'b0, 1'b1, 5'h00, 32'h0);
        expq.push_back({16'h0, a[15:0]});
        req(1'b0, 1'b1, 5'h0A, 32'h0);
        idle(2);
        drain();
        #1 check({31'h0, aif.in_fifo_empty}, 32'h1);
        @(posedge CLK);
        width16 <= 1'b0;
        serial_boot <= 1'b1;
        irq_sel_out <= 4'h8;
        boot_pins <= {1'b1, d[7:0]};
        expq.push_back({d[7:0], 24'h0});
        req(1'b0, 1'b0, 5'h07, 32'h0);
        idle(2);
        drain();
        #1 check({31'h0, bus_int_n}, 32'h0);
        repeat (5) @(posedge CLK);
        close_out();
    end
endmodule // addon_fifo_passthru_port_test
